/* rtcc_map.svh */
/*
 * Constants of the serial real-time clock core: timing counts,
 * register pointers, bit positions and reset values.
 * Assumes a 100 MHz system clock and a 32.768 kHz oscillator pin.
 */
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

`define RTCC_CLK_MHZ 100
`define RTCC_SPIKE_NS 50
`define RTCC_SPIKE_CYC ((`RTCC_SPIKE_NS * `RTCC_CLK_MHZ) / 1000)
`define RTCC_OSC_STOP_US 100
`define RTCC_OSC_STOP_CYC (`RTCC_OSC_STOP_US * `RTCC_CLK_MHZ)
`define RTCC_PRESC_WRAP 17'h07fff
`define RTCC_ADJ_SECONDS 5'h13
`define RTCC_DEV_ADDR 7'h32

`define RTCC_REG_SEC 4'h0
`define RTCC_REG_MIN 4'h1
`define RTCC_REG_HOUR 4'h2
`define RTCC_REG_WDAY 4'h3
`define RTCC_REG_MDAY 4'h4
`define RTCC_REG_MONTH 4'h5
`define RTCC_REG_YEAR 4'h6
`define RTCC_REG_ADJ 4'h7
`define RTCC_REG_WALM_MIN 4'h8
`define RTCC_REG_WALM_HOUR 4'h9
`define RTCC_REG_WALM_DAYS 4'ha
`define RTCC_REG_DALM_MIN 4'hb
`define RTCC_REG_DALM_HOUR 4'hc
`define RTCC_REG_CTRL1 4'he
`define RTCC_REG_CTRL2 4'hf

`define RTCC_C1_WALM_EN 7
`define RTCC_C1_DALM_EN 6
`define RTCC_C2_VSEL 7
`define RTCC_C2_VLOW 6
`define RTCC_C2_SCR1 5
`define RTCC_C2_HALT 4
`define RTCC_C2_SCR2 3
`define RTCC_C2_PFLAG 2
`define RTCC_C2_WFLAG 1
`define RTCC_C2_DFLAG 0
`define RTCC_MONTH_CENT 7

`define RTCC_CTRL_RESET 8'h00
`define RTCC_DAY_RESET 8'h01

`endif

/* rtcc_pkg.sv */
/*
 * Types of the serial real-time clock core.
 * Assumes nothing of its surroundings.
 */
package rtcc_pkg;

  typedef enum logic [3:0] {
    RTCC_IDLE = 4'b0000,
    RTCC_ADDR = 4'b0001,
    RTCC_ADDR_ACK = 4'b0010,
    RTCC_PTR = 4'b0011,
    RTCC_PTR_ACK = 4'b0100,
    RTCC_WDATA = 4'b0101,
    RTCC_WACK = 4'b0110,
    RTCC_RDATA = 4'b0111,
    RTCC_RACK = 4'b1000
  } rtcc_link_state_type;

  typedef enum logic [2:0] {
    RTCC_PER_OFF = 3'b000,
    RTCC_PER_LOW = 3'b001,
    RTCC_PER_2HZ = 3'b010,
    RTCC_PER_1HZ = 3'b011,
    RTCC_PER_SEC = 3'b100,
    RTCC_PER_MIN = 3'b101,
    RTCC_PER_HOUR = 3'b110,
    RTCC_PER_MONTH = 3'b111
  } rtcc_period_type;

endpackage : rtcc_pkg

/* rtcc_input_filter.sv */
/*
 * Two-flop synchroniser followed by a spike filter for one pin.
 * Assumes the pin is asynchronous to clk; the output moves only
 * after the input has held a new level for more than the spike count.
 */
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_input_filter #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw,
  output logic clean
);

  logic meta_reg;
  logic sync_reg;
  logic [3:0] stable_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_reg <= 4'h0;
      clean <= INIT;
    end else if (sync_reg == clean) begin
      stable_reg <= 4'h0;
    end else if (stable_reg == 4'(`RTCC_SPIKE_CYC)) begin
      clean <= sync_reg;
      stable_reg <= 4'h0;
    end else begin
      stable_reg <= stable_reg + 4'h1;
    end
  end

endmodule : rtcc_input_filter

/* rtcc_core.sv */
/*
 * Real-time clock core with two-wire serial register access, BCD
 * calendar, two alarms, periodic interrupt, rate trim and halt/supply flags.
 * Assumes SCL, SDA, oscillator, enable and comparator inputs come from pins;
 * the testbench resolves SDA and the interrupt lines from the enables.
 */
//Contract
//- Year with BCD value divisible by four is a leap year.
//- Century bit kept with year so year 00 leap handling is right.
//- Host reads and writes seconds through year registers.
//- Weekly alarm matches minute, hour and any enabled weekday.
//- Daily alarm matches hour and minute once a day.
//- Weekly alarm drives its line, daily alarm the shared line.
//- Each alarm has a readable flag mirroring its interrupt.
//- Rate trim in about 3 ppm steps over about 189 ppm.
//- Sticky flag records any oscillator stop lasting OSC_STOP_CYC system clocks or more.
//- Sticky flag records supply drop; a bit picks the threshold.
//- Periodic events drive the shared line independent of alarms.
//- Periodic rates 2 Hz, 1 Hz, minute, hour, month start.
//- Pulse waveform for fast rates, level waveform for slow rates.
//- Periodic interrupt state readable as a flag.
//- Clock output runs only while its enable pin is high.
//- SDA only pulled low or released, never driven high.
//- SCL and SDA spikes up to 50 ns are filtered out.
//- Disabled clock output held low.
//- Both interrupt lines released after power-on reset.
`timescale 1ns/10ps
`include "rtcc_map.svh"

module rtcc_core #(
  parameter int OSC_STOP_CYC = `RTCC_OSC_STOP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic OSC_IN,
  input wire logic CLOCK_OUT_ENABLE_PIN,
  input wire logic SUPPLY_BELOW_HIGH,
  input wire logic SUPPLY_BELOW_LOW,
  output logic CRYSTAL_CLOCK_OUT,
  output logic WEEKLY_ALARM_IRQ_N_O,
  output logic WEEKLY_ALARM_IRQ_N_OE,
  output logic ALARM_PERIODIC_IRQ_N_O,
  output logic ALARM_PERIODIC_IRQ_N_OE
);

  logic scl, sda, osc, clk_en, below_hi, below_lo;
  logic scl_prev_reg, sda_prev_reg, osc_prev_reg;
  logic [16:0] presc_reg;
  logic [4:0] adj_sec_reg;
  logic [19:0] osc_idle_reg;
  logic [7:0] sec_reg, min_reg, hour_reg, mday_reg, month_reg, year_reg;
  logic [2:0] wday_reg;
  logic century_reg;
  logic [6:0] adj_reg;
  logic [7:0] walm_min_reg, walm_hour_reg, dalm_min_reg, dalm_hour_reg;
  logic [6:0] walm_days_reg;
  logic [7:0] ctrl1_reg;
  logic vsel_reg, vlow_reg, scr1_reg, scr2_reg, halt_reg;
  logic pflag_reg, wflag_reg, dflag_reg;
  logic zero_reg, sda_oe_reg, walm_oe_reg, aper_oe_reg, clk_out_reg;
  rtcc_pkg::rtcc_link_state_type state_reg;
  logic [3:0] bitcnt_reg, ptr_reg;
  logic [7:0] shift_reg, tx_reg;
  logic rw_reg, nack_reg;
  logic wr_stb;
  logic [7:0] rd_data;
  logic start_cond, stop_cond, scl_rise, scl_fall, osc_rise;
  logic sec_tick, halt_set;
  logic c_min, c_hour, c_day, c_mon, c_year;
  logic [7:0] dim;
  logic leap;
  logic per_active;
  rtcc_pkg::rtcc_period_type per_mode;

  rtcc_input_filter #(.INIT(1'b1)) u_scl (.clk(SYS_CLK), .rst(RST), .raw(SCL_IN), .clean(scl));
  rtcc_input_filter #(.INIT(1'b1)) u_sda (.clk(SYS_CLK), .rst(RST), .raw(SDA_IN), .clean(sda));
  rtcc_input_filter #(.INIT(1'b0)) u_osc (.clk(SYS_CLK), .rst(RST), .raw(OSC_IN), .clean(osc));
  rtcc_input_filter #(.INIT(1'b0)) u_cen (.clk(SYS_CLK), .rst(RST), .raw(CLOCK_OUT_ENABLE_PIN), .clean(clk_en));
  rtcc_input_filter #(.INIT(1'b0)) u_vhi (.clk(SYS_CLK), .rst(RST), .raw(SUPPLY_BELOW_HIGH), .clean(below_hi));
  rtcc_input_filter #(.INIT(1'b0)) u_vlo (.clk(SYS_CLK), .rst(RST), .raw(SUPPLY_BELOW_LOW), .clean(below_lo));

  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max_v, input logic [7:0] min_v);
    if (v == max_v) begin
      bcd_inc = min_v;
    end else if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  always_comb begin
    leap = (year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6)
                        : (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 || year_reg[3:0] == 4'h8));
    if (year_reg == 8'h00 && !century_reg) begin
      leap = 1'b0;
    end
    case (month_reg[4:0])
      5'h02: dim = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  end

  assign start_cond = scl && scl_prev_reg && sda_prev_reg && !sda;
  assign stop_cond = scl && scl_prev_reg && !sda_prev_reg && sda;
  assign scl_rise = scl && !scl_prev_reg;
  assign scl_fall = !scl && scl_prev_reg;
  assign osc_rise = osc && !osc_prev_reg;
  assign sec_tick = osc_rise && (presc_reg == `RTCC_PRESC_WRAP);
  assign halt_set = (osc_idle_reg == 20'(OSC_STOP_CYC));
  assign wr_stb = scl_fall && (state_reg == rtcc_pkg::RTCC_WDATA) && (bitcnt_reg == 4'h8);
  assign c_min = sec_tick && (sec_reg == 8'h59);
  assign c_hour = c_min && (min_reg == 8'h59);
  assign c_day = c_hour && (hour_reg == 8'h23);
  assign c_mon = c_day && (mday_reg == dim);
  assign c_year = c_mon && (month_reg[4:0] == 5'h12);
  assign per_mode = rtcc_pkg::rtcc_period_type'(ctrl1_reg[2:0]);

  always_comb begin
    case (ptr_reg)
      `RTCC_REG_SEC: rd_data = sec_reg;
      `RTCC_REG_MIN: rd_data = min_reg;
      `RTCC_REG_HOUR: rd_data = hour_reg;
      `RTCC_REG_WDAY: rd_data = {5'h00, wday_reg};
      `RTCC_REG_MDAY: rd_data = mday_reg;
      `RTCC_REG_MONTH: rd_data = {century_reg, month_reg[6:0]};
      `RTCC_REG_YEAR: rd_data = year_reg;
      `RTCC_REG_ADJ: rd_data = {1'b0, adj_reg};
      `RTCC_REG_WALM_MIN: rd_data = walm_min_reg;
      `RTCC_REG_WALM_HOUR: rd_data = walm_hour_reg;
      `RTCC_REG_WALM_DAYS: rd_data = {1'b0, walm_days_reg};
      `RTCC_REG_DALM_MIN: rd_data = dalm_min_reg;
      `RTCC_REG_DALM_HOUR: rd_data = dalm_hour_reg;
      `RTCC_REG_CTRL1: rd_data = ctrl1_reg;
      `RTCC_REG_CTRL2: rd_data = {vsel_reg, vlow_reg, scr1_reg, halt_reg, scr2_reg, per_active, wflag_reg, dflag_reg};
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      osc_prev_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
      osc_prev_reg <= osc;
    end
  end

  // Serial slave; only ever pulls SDA low
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= rtcc_pkg::RTCC_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 4'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= rtcc_pkg::RTCC_ADDR;
      bitcnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= rtcc_pkg::RTCC_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        rtcc_pkg::RTCC_ADDR, rtcc_pkg::RTCC_PTR, rtcc_pkg::RTCC_WDATA: begin
          shift_reg <= {shift_reg[6:0], sda};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end
        rtcc_pkg::RTCC_RDATA: bitcnt_reg <= bitcnt_reg + 4'h1;
        rtcc_pkg::RTCC_RACK: nack_reg <= sda;
        default: bitcnt_reg <= bitcnt_reg;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        rtcc_pkg::RTCC_ADDR: begin
          if (bitcnt_reg == 4'h8) begin
            if (shift_reg[7:1] == `RTCC_DEV_ADDR) begin
              rw_reg <= shift_reg[0];
              sda_oe_reg <= 1'b1;
              state_reg <= rtcc_pkg::RTCC_ADDR_ACK;
            end else begin
              state_reg <= rtcc_pkg::RTCC_IDLE;
            end
          end
        end
        rtcc_pkg::RTCC_ADDR_ACK, rtcc_pkg::RTCC_RACK: begin
          bitcnt_reg <= 4'h0;
          if ((state_reg == rtcc_pkg::RTCC_RACK && nack_reg) ||
              (state_reg == rtcc_pkg::RTCC_ADDR_ACK && !rw_reg)) begin
            sda_oe_reg <= 1'b0;
            state_reg <= (state_reg == rtcc_pkg::RTCC_RACK) ? rtcc_pkg::RTCC_IDLE : rtcc_pkg::RTCC_PTR;
          end else begin
            sda_oe_reg <= !rd_data[7];
            tx_reg <= {rd_data[6:0], 1'b0};
            state_reg <= rtcc_pkg::RTCC_RDATA;
          end
        end
        rtcc_pkg::RTCC_PTR: begin
          if (bitcnt_reg == 4'h8) begin
            ptr_reg <= shift_reg[3:0];
            sda_oe_reg <= 1'b1;
            state_reg <= rtcc_pkg::RTCC_PTR_ACK;
          end
        end
        rtcc_pkg::RTCC_WDATA: begin
          if (bitcnt_reg == 4'h8) begin
            ptr_reg <= ptr_reg + 4'h1;
            sda_oe_reg <= 1'b1;
            state_reg <= rtcc_pkg::RTCC_WACK;
          end
        end
        rtcc_pkg::RTCC_PTR_ACK, rtcc_pkg::RTCC_WACK: begin
          sda_oe_reg <= 1'b0;
          bitcnt_reg <= 4'h0;
          state_reg <= rtcc_pkg::RTCC_WDATA;
        end
        rtcc_pkg::RTCC_RDATA: begin
          if (bitcnt_reg == 4'h8) begin
            sda_oe_reg <= 1'b0;
            ptr_reg <= ptr_reg + 4'h1;
            state_reg <= rtcc_pkg::RTCC_RACK;
          end else begin
            sda_oe_reg <= !tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        default: state_reg <= rtcc_pkg::RTCC_IDLE;
      endcase
    end
  end

  // Prescaler; every 20 s the reload skews the count by 2 ticks per step (~3 ppm)
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      presc_reg <= 17'h00000;
      adj_sec_reg <= 5'h00;
    end else if (wr_stb && ptr_reg == `RTCC_REG_SEC) begin
      presc_reg <= 17'h00000;
    end else if (sec_tick) begin
      adj_sec_reg <= (adj_sec_reg == `RTCC_ADJ_SECONDS) ? 5'h00 : adj_sec_reg + 5'h01;
      if (adj_sec_reg != `RTCC_ADJ_SECONDS || adj_reg[6:1] == 6'h00) begin
        presc_reg <= 17'h00000;
      end else if (!adj_reg[6]) begin
        presc_reg <= {10'h000, adj_reg[5:0] - 6'h01, 1'b0};
      end else begin
        presc_reg <= 17'h00000 - {9'h000, 7'h00 - adj_reg, 1'b0};
      end
    end else if (osc_rise) begin
      presc_reg <= presc_reg + 17'h00001;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      osc_idle_reg <= 20'h00000;
    end else if (osc_rise) begin
      osc_idle_reg <= 20'h00000;
    end else if (!halt_set) begin
      osc_idle_reg <= osc_idle_reg + 20'h00001;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sec_reg <= 8'h00;
      min_reg <= 8'h00;
      hour_reg <= 8'h00;
      wday_reg <= 3'h0;
      mday_reg <= `RTCC_DAY_RESET;
      month_reg <= `RTCC_DAY_RESET;
      century_reg <= 1'b0;
      year_reg <= 8'h00;
    end else if (wr_stb) begin
      case (ptr_reg)
        `RTCC_REG_SEC: sec_reg <= {1'b0, shift_reg[6:0]};
        `RTCC_REG_MIN: min_reg <= {1'b0, shift_reg[6:0]};
        `RTCC_REG_HOUR: hour_reg <= {2'h0, shift_reg[5:0]};
        `RTCC_REG_WDAY: wday_reg <= shift_reg[2:0];
        `RTCC_REG_MDAY: mday_reg <= {2'h0, shift_reg[5:0]};
        `RTCC_REG_MONTH: begin
          month_reg <= {3'h0, shift_reg[4:0]};
          century_reg <= shift_reg[`RTCC_MONTH_CENT];
        end
        `RTCC_REG_YEAR: year_reg <= shift_reg;
        default: sec_reg <= sec_reg;
      endcase
    end else if (sec_tick) begin
      sec_reg <= bcd_inc(sec_reg, 8'h59, 8'h00);
      if (c_min) min_reg <= bcd_inc(min_reg, 8'h59, 8'h00);
      if (c_hour) hour_reg <= bcd_inc(hour_reg, 8'h23, 8'h00);
      if (c_day) begin
        wday_reg <= (wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'h1;
        mday_reg <= bcd_inc(mday_reg, dim, 8'h01);
      end
      if (c_mon) month_reg <= bcd_inc(month_reg, 8'h12, 8'h01);
      if (c_year) begin
        year_reg <= bcd_inc(year_reg, 8'h99, 8'h00);
        if (year_reg == 8'h99) century_reg <= !century_reg;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      walm_min_reg <= 8'h00;
      walm_hour_reg <= 8'h00;
      walm_days_reg <= 7'h00;
      dalm_min_reg <= 8'h00;
      dalm_hour_reg <= 8'h00;
    end else if (wr_stb) begin
      case (ptr_reg)
        `RTCC_REG_WALM_MIN: walm_min_reg <= {1'b0, shift_reg[6:0]};
        `RTCC_REG_WALM_HOUR: walm_hour_reg <= {2'h0, shift_reg[5:0]};
        `RTCC_REG_WALM_DAYS: walm_days_reg <= shift_reg[6:0];
        `RTCC_REG_DALM_MIN: dalm_min_reg <= {1'b0, shift_reg[6:0]};
        `RTCC_REG_DALM_HOUR: dalm_hour_reg <= {2'h0, shift_reg[5:0]};
        default: walm_min_reg <= walm_min_reg;
      endcase
    end
  end

  // Oscillator halt wipes trim and control, keeping only the halt flag
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      adj_reg <= 7'h00;
      ctrl1_reg <= `RTCC_CTRL_RESET;
      vsel_reg <= 1'b0;
      scr1_reg <= 1'b0;
      scr2_reg <= 1'b0;
    end else if (halt_set) begin
      adj_reg <= 7'h00;
      ctrl1_reg <= `RTCC_CTRL_RESET;
      vsel_reg <= 1'b0;
      scr1_reg <= 1'b0;
      scr2_reg <= 1'b0;
    end else if (wr_stb && ptr_reg == `RTCC_REG_ADJ) begin
      adj_reg <= shift_reg[6:0];
    end else if (wr_stb && ptr_reg == `RTCC_REG_CTRL1) begin
      ctrl1_reg <= shift_reg;
    end else if (wr_stb && ptr_reg == `RTCC_REG_CTRL2) begin
      vsel_reg <= shift_reg[`RTCC_C2_VSEL];
      scr1_reg <= shift_reg[`RTCC_C2_SCR1];
      scr2_reg <= shift_reg[`RTCC_C2_SCR2];
    end
  end

  // Sticky flags: writing 0 clears, a same-cycle event still sets
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      halt_reg <= 1'b1;
      vlow_reg <= 1'b0;
      wflag_reg <= 1'b0;
      dflag_reg <= 1'b0;
      pflag_reg <= 1'b0;
    end else begin
      if (halt_set) begin
        halt_reg <= 1'b1;
      end else if (wr_stb && ptr_reg == `RTCC_REG_CTRL2 && !shift_reg[`RTCC_C2_HALT]) begin
        halt_reg <= 1'b0;
      end
      if (vsel_reg ? below_lo : below_hi) begin
        vlow_reg <= 1'b1;
      end else if (halt_set || (wr_stb && ptr_reg == `RTCC_REG_CTRL2 && !shift_reg[`RTCC_C2_VLOW])) begin
        vlow_reg <= 1'b0;
      end
      // Weekday 6 rolls to 0, never to a bit past the mask
      if (ctrl1_reg[`RTCC_C1_WALM_EN] && c_min &&
          walm_days_reg[(c_day && wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'(c_day)] &&
          walm_min_reg == bcd_inc(min_reg, 8'h59, 8'h00) &&
          walm_hour_reg == (c_hour ? bcd_inc(hour_reg, 8'h23, 8'h00) : hour_reg)) begin
        wflag_reg <= 1'b1;
      end else if (halt_set || !ctrl1_reg[`RTCC_C1_WALM_EN] ||
                   (wr_stb && ptr_reg == `RTCC_REG_CTRL2 && !shift_reg[`RTCC_C2_WFLAG])) begin
        wflag_reg <= 1'b0;
      end
      if (ctrl1_reg[`RTCC_C1_DALM_EN] && c_min && dalm_min_reg == bcd_inc(min_reg, 8'h59, 8'h00) &&
          dalm_hour_reg == (c_hour ? bcd_inc(hour_reg, 8'h23, 8'h00) : hour_reg)) begin
        dflag_reg <= 1'b1;
      end else if (halt_set || !ctrl1_reg[`RTCC_C1_DALM_EN] ||
                   (wr_stb && ptr_reg == `RTCC_REG_CTRL2 && !shift_reg[`RTCC_C2_DFLAG])) begin
        dflag_reg <= 1'b0;
      end
      if ((per_mode == rtcc_pkg::RTCC_PER_SEC && sec_tick) || (per_mode == rtcc_pkg::RTCC_PER_MIN && c_min) ||
          (per_mode == rtcc_pkg::RTCC_PER_HOUR && c_hour) || (per_mode == rtcc_pkg::RTCC_PER_MONTH && c_mon)) begin
        pflag_reg <= 1'b1;
      end else if (halt_set || (wr_stb && ptr_reg == `RTCC_REG_CTRL2 && !shift_reg[`RTCC_C2_PFLAG])) begin
        pflag_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    case (per_mode)
      rtcc_pkg::RTCC_PER_OFF: per_active = 1'b0;
      rtcc_pkg::RTCC_PER_LOW: per_active = 1'b1;
      rtcc_pkg::RTCC_PER_2HZ: per_active = !presc_reg[13];
      rtcc_pkg::RTCC_PER_1HZ: per_active = !presc_reg[14];
      default: per_active = pflag_reg;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      zero_reg <= 1'b0;
      walm_oe_reg <= 1'b0;
      aper_oe_reg <= 1'b0;
      clk_out_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
      walm_oe_reg <= ctrl1_reg[`RTCC_C1_WALM_EN] && wflag_reg;
      aper_oe_reg <= (ctrl1_reg[`RTCC_C1_DALM_EN] && dflag_reg) || per_active;
      clk_out_reg <= clk_en && osc;
    end
  end

  assign SDA_OUT = zero_reg;
  assign SDA_OE = sda_oe_reg;
  assign WEEKLY_ALARM_IRQ_N_O = zero_reg;
  assign WEEKLY_ALARM_IRQ_N_OE = walm_oe_reg;
  assign ALARM_PERIODIC_IRQ_N_O = zero_reg;
  assign ALARM_PERIODIC_IRQ_N_OE = aper_oe_reg;
  assign CRYSTAL_CLOCK_OUT = clk_out_reg;

endmodule : rtcc_core

/* rtcc_core_checker.sv */
/* Pin-level assertions for the serial real-time clock core.
   Assumes it is bound to rtcc_core and shares its clock and reset. */
`timescale 1ns/10ps
module rtcc_core_checker #(
  parameter int OSC_STOP_CYC = 10000
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic CLOCK_OUT_ENABLE_PIN,
  input wire logic CRYSTAL_CLOCK_OUT,
  input wire logic WEEKLY_ALARM_IRQ_N_O,
  input wire logic WEEKLY_ALARM_IRQ_N_OE,
  input wire logic ALARM_PERIODIC_IRQ_N_O,
  input wire logic ALARM_PERIODIC_IRQ_N_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [4:0] en_low_reg;
  // Age of the last high enable level, saturating
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      en_low_reg <= 5'h00;
    end else if (CLOCK_OUT_ENABLE_PIN) begin
      en_low_reg <= 5'h00;
    end else if (en_low_reg != 5'h1f) begin
      en_low_reg <= en_low_reg + 5'h01;
    end
  end
  a_sda_never_high: assert property (!SDA_OUT)
    else $error("SDA driven high");
  a_ack_drive_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
    else $error("SDA pull started while SCL high");
  a_ack_release_low: assert property ($fell(SDA_OE) |-> !SCL_IN)
    else $error("SDA released while SCL high");
  a_irq_open_drain: assert property (!WEEKLY_ALARM_IRQ_N_O && !ALARM_PERIODIC_IRQ_N_O)
    else $error("Interrupt line driven high");
  a_irq_reset_off: assert property ($fell(RST) |-> (!WEEKLY_ALARM_IRQ_N_OE && !ALARM_PERIODIC_IRQ_N_OE)[*4])
    else $error("Interrupt line active after reset");
  a_sda_reset_idle: assert property ($fell(RST) |-> (!SDA_OE)[*8])
    else $error("SDA pulled after reset");
  a_clkout_gated_low: assert property (en_low_reg >= 5'h0c |-> !CRYSTAL_CLOCK_OUT)
    else $error("Clock output not held low while disabled");
  a_clkout_rise_enabled: assert property ($rose(CRYSTAL_CLOCK_OUT) |-> en_low_reg < 5'h0c)
    else $error("Clock output rose while disabled");
  c_sda_ack: cover property ($rose(SDA_OE));
  c_periodic_irq: cover property ($rose(ALARM_PERIODIC_IRQ_N_OE));
  c_clock_out: cover property ($rose(CRYSTAL_CLOCK_OUT));
endmodule : rtcc_core_checker

bind rtcc_core rtcc_core_checker #(.OSC_STOP_CYC(OSC_STOP_CYC)) chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CLOCK_OUT_ENABLE_PIN(CLOCK_OUT_ENABLE_PIN),
  .CRYSTAL_CLOCK_OUT(CRYSTAL_CLOCK_OUT), .WEEKLY_ALARM_IRQ_N_O(WEEKLY_ALARM_IRQ_N_O),
  .WEEKLY_ALARM_IRQ_N_OE(WEEKLY_ALARM_IRQ_N_OE), .ALARM_PERIODIC_IRQ_N_O(ALARM_PERIODIC_IRQ_N_O),
  .ALARM_PERIODIC_IRQ_N_OE(ALARM_PERIODIC_IRQ_N_OE));

/* rtcc_host_model.sv */
/* Bus master model: drives SCL, pulls SDA low or releases it.
   Assumes the bench resolves SDA through a pull-up. */
`timescale 1ns/10ps
module rtcc_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw
  // 400 kHz bit: 1.9 us low, 0.6 us high, never above the fast-mode limit
  task automatic bit_x(input logic b, input logic gl, output logic s);
    hw(40);
    sda_low = !b;
    hw(10);
    if (gl) begin
      // Spike of 50 ns, the widest the filter must swallow
      scl = 1'b1;
      hw(5);
      scl = 1'b0;
    end
    hw(140);
    scl = 1'b1;
    hw(30);
    s = sda;
    hw(30);
    scl = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic a, input logic gl, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], gl && (i == 4), s);
      q[i] = s;
    end
    bit_x(a, 1'b0, ack);
  endtask : xfer
  // Long settle lets a repeated start follow the device's acknowledge
  task automatic start_c();
    sda_low = 1'b0;
    hw(60);
    scl = 1'b1;
    hw(60);
    sda_low = 1'b1;
    hw(60);
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    hw(30);
    sda_low = 1'b1;
    hw(100);
    scl = 1'b1;
    hw(60);
    sda_low = 1'b0;
    hw(130);
  endtask : stop_c
endmodule : rtcc_host_model

/* rtcc_core_tb_top.sv */
/* Self-checking bench for the serial real-time clock core.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/10ps
`include "rtcc_map.svh"
module rtcc_core_tb_top;
  logic clk, rst, osc, osc_run, clk_en, below_hi, below_lo, scl, sda_low, sda, a;
  logic sda_out, sda_oe, ck_out, wb_o, wb_oe, ap_o, ap_oe, irqa_n, irqb_n;
  logic [7:0] q;
  int errors, total_checks, cycles, c;
  assign sda = !sda_low && (sda_oe ? sda_out : 1'b1);
  assign irqa_n = ap_oe ? ap_o : 1'b1;
  assign irqb_n = wb_oe ? wb_o : 1'b1;
  rtcc_core #(.OSC_STOP_CYC(200)) dut (.SYS_CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .OSC_IN(osc), .CLOCK_OUT_ENABLE_PIN(clk_en), .SUPPLY_BELOW_HIGH(below_hi),
    .SUPPLY_BELOW_LOW(below_lo), .CRYSTAL_CLOCK_OUT(ck_out), .WEEKLY_ALARM_IRQ_N_O(wb_o),
    .WEEKLY_ALARM_IRQ_N_OE(wb_oe), .ALARM_PERIODIC_IRQ_N_O(ap_o), .ALARM_PERIODIC_IRQ_N_OE(ap_oe));
  rtcc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (10) @(negedge clk);
      if (osc_run) osc = !osc;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 150000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic addr(input logic rw);
    host.xfer({`RTCC_DEV_ADDR, rw}, 1'b1, 1'b0, q, a);
    check("addr_ack", {7'h00, a}, 8'h00);
  endtask : addr
  task automatic wr(input logic [3:0] p, input int n, input logic [71:0] v, input logic gl);
    host.start_c();
    addr(1'b0);
    host.xfer({4'h0, p}, 1'b1, 1'b0, q, a);
    for (int i = 0; i < n; i++) begin
      host.xfer(v[8*(n-1-i) +: 8], 1'b1, gl, q, a);
      check("data_ack", {7'h00, a}, 8'h00);
    end
    host.stop_c();
  endtask : wr
  // Pointer set by a write, then a repeated start into the read
  task automatic rc(input logic [3:0] p, input int n, input logic [71:0] e);
    host.start_c();
    addr(1'b0);
    host.xfer({4'h0, p}, 1'b1, 1'b0, q, a);
    host.start_c();
    addr(1'b1);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hff, i == n - 1, 1'b0, q, a);
      check($sformatf("reg_%h", 4'(p + i)), q, e[8*(n-1-i) +: 8]);
    end
    host.stop_c();
  endtask : rc
  task automatic cnt(input int n);
    logic last;
    c = 0;
    last = ck_out;
    repeat (n) begin
      @(negedge clk);
      if (ck_out === 1'b1 && last === 1'b0) c++;
      last = ck_out;
    end
  endtask : cnt
  initial begin
    {rst, osc, osc_run, clk_en, below_hi, below_lo} = 6'b101000;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    check("irq_lines", {6'h00, irqa_n, irqb_n}, 8'h03);
    check("clock_out", {7'h00, ck_out}, 8'h00);
    rc(4'he, 9, 72'h00_10_00_00_00_00_01_01_00);
    wr(4'h0, 7, 72'hd9_59_e3_06_31_92_99, 1'b1);
    rc(4'h0, 7, 72'h59_59_23_06_31_92_99);
    host.start_c();
    host.xfer({`RTCC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, 1'b0, q, a);
    check("foreign_addr", {7'h00, a}, 8'h01);
    host.stop_c();
    wr(4'hd, 3, 72'hff_01_00, 1'b0);
    below_hi = 1'b1;
    repeat (20) @(negedge clk);
    below_hi = 1'b0;
    check("irq_lines", {6'h00, irqa_n, irqb_n}, 8'h01);
    rc(4'hd, 3, 72'h00_01_44);
    wr(4'he, 2, 72'h10_80, 1'b0);
    check("irq_lines", {6'h00, irqa_n, irqb_n}, 8'h03);
    // Supply dips are pulses: no transfer runs on a low supply
    below_hi = 1'b1;
    repeat (20) @(negedge clk);
    below_hi = 1'b0;
    rc(4'hf, 1, 72'h80);
    {below_hi, below_lo} = 2'b11;
    repeat (20) @(negedge clk);
    {below_hi, below_lo} = 2'b00;
    rc(4'hf, 1, 72'hc0);
    clk_en = 1'b1;
    repeat (50) @(negedge clk);
    cnt(2000);
    check("clock_rises", {7'h00, c >= 99 && c <= 101}, 8'h01);
    clk_en = 1'b0;
    repeat (50) @(negedge clk);
    cnt(500);
    check("clock_idle", {7'h00, c == 0 && ck_out === 1'b0}, 8'h01);
    osc_run = 1'b0;
    repeat (500) @(negedge clk);
    osc_run = 1'b1;
    rc(4'he, 2, 72'h00_10);
    report_and_stop();
  end
endmodule : rtcc_core_tb_top
